// file: dv/pevi_link_asserts.sv
// Handshake and read-data checks on the management link
`timescale 1ns/10ps
`include "pevi_map.svh"
module pevi_link_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic req,
  input wire logic wr,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic [15:0] rdata
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_ACK_PULSE: assert property (ack |=> !ack) else $error("ack wider than one cycle");
  AST_ACK_CAUSE: assert property (ack |-> req && $past(req)) else $error("ack without request");
  AST_ACK_PROMPT: assert property ($rose(req) |=> ack) else $error("ack late");
  AST_REQ_HOLD: assert property (req && !ack |=> req) else $error("request dropped early");
  AST_REQ_DROP: assert property (ack |=> !req) else $error("request held after ack");
  AST_REQ_STABLE: assert property (req && !ack |=> $stable(addr) && $stable(wr) && $stable(wdata))
    else $error("request changed while waiting");
  AST_NONMAP_ZERO: assert property (ack && !wr && addr != `PEVI_OFS_EVENT_STATUS |-> rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_RDATA_HOLD: assert property (ack && wr |-> $stable(rdata)) else $error("read data moved on write");
endmodule

// file: dv/testbench.sv
// Bench joining host and device ends, plus a directly driven device
`timescale 1ns/10ps
`include "pevi_map.svh"
module testbench;
  logic hclk = 0, hresetn = 0, hwrite = 0, link_up = 1, test_irq = 0, gen = 0, pol = 1;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0] htrans = 0;
  logic [7:0] ev = 0;
  wire logic hreadyout, hresp, irq_global_en, irq_polarity, irq_out_en, pin_o, pin_oe, act, pin2, oe2, act2;
  wire logic [31:0] hrdata;
  int miscompares = 0, n_compared = 0, en, a, k;
  pevi_if mgmt_a ();
  pevi_if mgmt_b ();
  always #20 hclk = ~hclk;
  pevi_host pevi_host_i (.hclk, .hresetn, .hsel(1'h1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .mgmt(mgmt_a), .irq_global_en, .irq_polarity,
    .irq_out_en, .irq_pin_level(pin_oe ? pin_o : 1'h1));
  pevi_device pevi_device_i (.hclk, .hresetn, .mgmt(mgmt_a), .link_up, .link_quality(ev[7]),
    .energy_det(ev[6]), .link_status(ev[5]), .speed_status(ev[4]), .duplex_status(ev[3]), .aneg_done(ev[2]),
    .fc_half_full(ev[1]), .rx_half_full(ev[0]), .irq_global_en, .irq_polarity, .irq_out_en, .test_irq,
    .irq_or_powerdown_pin_o(pin_o), .irq_or_powerdown_pin_oe(pin_oe), .irq_active(act));
  // Second device reached straight from the bench over mgmt_b, with its own enable and polarity inputs
  pevi_device pevi_device_i2 (.hclk, .hresetn, .mgmt(mgmt_b), .link_up, .link_quality(ev[7]),
    .energy_det(ev[6]), .link_status(ev[5]), .speed_status(ev[4]), .duplex_status(ev[3]), .aneg_done(ev[2]),
    .fc_half_full(ev[1]), .rx_half_full(ev[0]), .irq_global_en(gen), .irq_polarity(pol), .irq_out_en(1'h1),
    .test_irq, .irq_or_powerdown_pin_o(pin2), .irq_or_powerdown_pin_oe(oe2), .irq_active(act2));
  pevi_link_asserts pevi_link_asserts_i (.hclk, .hresetn, .req(mgmt_a.req), .wr(mgmt_a.wr),
    .addr(mgmt_a.addr), .wdata(mgmt_a.wdata), .ack(mgmt_a.ack), .rdata(mgmt_a.rdata));
  task chk(logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up();
    if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task rdy(bit lk);
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while ((lk ? mgmt_b.ack : hreadyout) !== 1'h1 && k < 50);
    if (k >= 50) begin
      miscompares++;
      wrap_up();
    end
  endtask
  task ahb(logic w, logic [7:0] ad, logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= 32'(ad);
    hwrite <= w;
    rdy(0);
    htrans <= 2'h0;
    hwdata <= d;
    rdy(0);
    rd = hrdata;
  endtask
  task lnk(logic w, logic [15:0] d);
    @(posedge hclk);
    mgmt_b.req <= 1'h1;
    mgmt_b.wr <= w;
    mgmt_b.wdata <= d;
    rdy(1);
    rd = 32'(mgmt_b.rdata);
    mgmt_b.req <= 1'h0;
  endtask
  initial begin
    mgmt_b.req = 0;
    mgmt_b.wr = 0;
    mgmt_b.wdata = 0;
    mgmt_b.addr = `PEVI_OFS_EVENT_STATUS;
    k = $urandom(32'h0000_7b52);
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    lnk(0, 0);
    chk(rd, `PEVI_RST_EVENT_STATUS);
    chk(pin2, 1);
    ahb(0, `PEVI_AHB_CTRL, 0);
    chk(rd, `PEVI_RST_CTRL);
    ahb(0, 8'h40, 0);
    chk(rd, 0);
    chk(hresp, 0);
    en = $urandom & 255;
    lnk(1, 16'(en));
    lnk(0, 0);
    chk(rd, en);
    for (int i = 0; i < 8; i++) begin
      gen <= i[0];
      pol <= i[1];
      ev[i] <= 1'h1;
      repeat (3) @(posedge hclk);
      a = gen && ((1 << i) & en) != 0;
      chk(act2, a);
      chk(pin2, pol ? !a : a);
      lnk(0, 0);
      chk(rd, (1 << (i + 8)) | en);
      lnk(0, 0);
      chk(rd, en);
      chk(act2, 0);
    end
    link_up <= 0;
    ev[7] <= 0;
    repeat (3) @(posedge hclk);
    lnk(0, 0);
    chk(rd, en);
    test_irq <= 1;
    repeat (2) @(posedge hclk);
    chk({act, act2}, 3);
    test_irq <= 0;
    ahb(1, `PEVI_AHB_CTRL, 32'h0000_0007);
    ahb(0, `PEVI_AHB_CTRL, 0);
    chk(rd, 7);
    chk({irq_out_en, irq_polarity, irq_global_en, pin_oe}, 15);
    ahb(0, `PEVI_AHB_PIN, 0);
    chk(rd, 1);
    // All eight events reached the host-side device too; write its enables, then read twice
    for (int c = 0; c < 3; c++) begin
      ahb(1, `PEVI_AHB_CMD, c == 0 ? 32'h0212_005a : 32'h0112_0000);
      rd = 1;
      for (int j = 0; j < 20 && rd[0] !== 1'h0; j++) ahb(0, `PEVI_AHB_STAT, 0);
      chk(rd[0], 0);
      ahb(0, `PEVI_AHB_RESULT, 0);
      chk(rd, c == 0 ? 32'h0000_0000 : (c == 1 ? 32'h0000_ff5a : 32'h0000_005a));
      if (c == 0) begin
        ahb(0, `PEVI_AHB_PIN, 0);
        chk(rd, 0);
      end
    end
    wrap_up();
  end
endmodule

// file: inc/pevi_if.sv
// Management link between the event status device and its host
`timescale 1ns/10ps
interface pevi_if;
  logic req;
  logic wr;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;
  modport dev (input req, input wr, input addr, input wdata, output ack, output rdata);
  modport host (output req, output wr, output addr, output wdata, input ack, input rdata);
endinterface

// file: inc/pevi_map.svh
// Offsets, field positions, reset values and command codes for the PHY event status block
`ifndef PEVI_MAP_SVH
`define PEVI_MAP_SVH
`define PEVI_OFS_EVENT_STATUS 5'h12
`define PEVI_OFS_FC_COUNT 5'h14
`define PEVI_OFS_RX_COUNT 5'h15
`define PEVI_RST_EVENT_STATUS 16'h0000
`define PEVI_BIT_LQ 15
`define PEVI_BIT_ED 14
`define PEVI_BIT_LINK 13
`define PEVI_BIT_SPEED 12
`define PEVI_BIT_DUPLEX 11
`define PEVI_BIT_ANEG 10
`define PEVI_BIT_FC_HF 9
`define PEVI_BIT_RX_HF 8
`define PEVI_PEND_LSB 8
`define PEVI_EN_MSB 7
`define PEVI_CTRL_IRQ_EN 0
`define PEVI_CTRL_POL 1
`define PEVI_CTRL_OUT_EN 2
`define PEVI_RST_CTRL 32'h0000_0002
`define PEVI_AHB_CTRL 8'h00
`define PEVI_AHB_STAT 8'h04
`define PEVI_AHB_CMD 8'h08
`define PEVI_AHB_RESULT 8'h0c
`define PEVI_AHB_PIN 8'h10
// Command word: [25:24] operation, [20:16] device offset, [15:0] write data
`define PEVI_CMD_READ 2'b01
`define PEVI_CMD_WRITE 2'b10
`endif

// file: inc/pevi_pkg.sv
// Types shared by both ends of the PHY event status link
package pevi_pkg;
  typedef enum logic [2:0] {
    PEVI_H_IDLE = 3'b001,
    PEVI_H_REQ = 3'b010,
    PEVI_H_DONE = 3'b100
  } pevi_hstate_t;

  typedef struct packed {
    logic [7:0] pend;
    logic [7:0] en;
    logic [15:0] rdata;
    logic ack;
    logic [7:0] prev_ev;
  } pevi_dev_t;

  typedef struct packed {
    pevi_hstate_t st;
    logic [2:0] ctrl;
    logic busy;
    logic [4:0] addr;
    logic wr;
    logic [15:0] wdata;
    logic [15:0] result;
    logic hready_out;
    logic [31:0] hrdata;
    logic dphase;
    logic dwrite;
    logic [7:0] daddr;
  } pevi_host_t;
endpackage

// file: rtl/pevi_device.sv
// Event status/enable register with interrupt pin drive, device end
`timescale 1ns/10ps
`include "pevi_map.svh"
module pevi_device (
  input wire logic hclk,
  input wire logic hresetn,
  pevi_if.dev mgmt,
  input wire logic link_up,
  input wire logic link_quality,
  input wire logic energy_det,
  input wire logic link_status,
  input wire logic speed_status,
  input wire logic duplex_status,
  input wire logic aneg_done,
  input wire logic fc_half_full,
  input wire logic rx_half_full,
  input wire logic irq_global_en,
  input wire logic irq_polarity,
  input wire logic irq_out_en,
  input wire logic test_irq,
  output logic irq_or_powerdown_pin_o,
  output logic irq_or_powerdown_pin_oe,
  output logic irq_active
);
  // ==========================================================
  // State
  pevi_pkg::pevi_dev_t s_r;
  pevi_pkg::pevi_dev_t s_nxt;
  logic [7:0] ev_now;
  logic [7:0] hit;
  logic rd_evt;
  logic wr_evt;
  logic irq_any;

  function automatic logic addr_hit(input logic [4:0] a);
    addr_hit = (a == `PEVI_OFS_EVENT_STATUS);
  endfunction

  // Order matches status bits 15..8
  assign ev_now = {link_quality, energy_det, link_status, speed_status,
                   duplex_status, aneg_done, fc_half_full, rx_half_full};
  assign rd_evt = mgmt.req && !s_r.ack && !mgmt.wr && addr_hit(mgmt.addr);
  assign wr_evt = mgmt.req && !s_r.ack && mgmt.wr && addr_hit(mgmt.addr);

  // ==========================================================
  // Event detection
  always_comb begin
    hit = ev_now ^ s_r.prev_ev;
    hit[7] = hit[7] && link_up;
    hit[2] = ev_now[2] && !s_r.prev_ev[2];
    hit[1] = ev_now[1] && !s_r.prev_ev[1];
    hit[0] = ev_now[0] && !s_r.prev_ev[0];
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.prev_ev = ev_now;
    s_nxt.ack = mgmt.req && !s_r.ack;
    if (rd_evt) begin
      s_nxt.rdata = {s_r.pend, s_r.en};
      s_nxt.pend = 8'h00;
    end else if (mgmt.req && !s_r.ack && !mgmt.wr) begin
      s_nxt.rdata = 16'h0000;
    end
    if (wr_evt) begin
      s_nxt.en = mgmt.wdata[`PEVI_EN_MSB:0];
    end
    // Set wins over the read clear
    s_nxt.pend = s_nxt.pend | hit;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Interrupt pin
  assign irq_any = (irq_global_en && |(s_r.pend & s_r.en)) || test_irq;
  assign irq_active = irq_any;
  assign irq_or_powerdown_pin_o = irq_polarity ? !irq_any : irq_any;
  assign irq_or_powerdown_pin_oe = irq_out_en;
  assign mgmt.ack = s_r.ack;
  assign mgmt.rdata = s_r.rdata;
endmodule

// file: rtl/pevi_host.sv
// Host end: AHB-Lite registers that drive management accesses to the device
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/10ps
`include "pevi_map.svh"
module pevi_host (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  pevi_if.host mgmt,
  output logic irq_global_en,
  output logic irq_polarity,
  output logic irq_out_en,
  input wire logic irq_pin_level
);
  // ==========================================================
  // State
  pevi_pkg::pevi_host_t s_r;
  pevi_pkg::pevi_host_t s_nxt;
  logic take;

  assign take = hsel && hready && htrans[1];

  always_comb begin
    s_nxt = s_r;
    s_nxt.hready_out = 1'b1;
    s_nxt.dphase = take;
    s_nxt.dwrite = hwrite;
    s_nxt.daddr = haddr[7:0];
    if (s_r.dphase && s_r.dwrite) begin
      case (s_r.daddr)
        `PEVI_AHB_CTRL: s_nxt.ctrl = hwdata[2:0];
        `PEVI_AHB_CMD: begin
          if (!s_r.busy && (hwdata[25:24] == `PEVI_CMD_READ || hwdata[25:24] == `PEVI_CMD_WRITE)) begin
            s_nxt.busy = 1'b1;
            s_nxt.wr = (hwdata[25:24] == `PEVI_CMD_WRITE);
            s_nxt.addr = hwdata[20:16];
            s_nxt.wdata = hwdata[15:0];
          end
        end
        default: s_nxt.ctrl = s_r.ctrl;
      endcase
    end
    if (take && !hwrite) begin
      case (haddr[7:0])
        `PEVI_AHB_CTRL: s_nxt.hrdata = {29'h0000_0000, s_r.ctrl};
        `PEVI_AHB_STAT: s_nxt.hrdata = {31'h0000_0000, s_r.busy};
        `PEVI_AHB_RESULT: s_nxt.hrdata = {16'h0000, s_r.result};
        `PEVI_AHB_PIN: s_nxt.hrdata = {31'h0000_0000, irq_pin_level};
        default: s_nxt.hrdata = 32'h0000_0000;
      endcase
    end
    case (s_r.st)
      pevi_pkg::PEVI_H_IDLE: begin
        if (s_r.busy) begin
          s_nxt.st = pevi_pkg::PEVI_H_REQ;
        end
      end
      pevi_pkg::PEVI_H_REQ: begin
        if (mgmt.ack) begin
          s_nxt.result = mgmt.rdata;
          s_nxt.st = pevi_pkg::PEVI_H_DONE;
        end
      end
      pevi_pkg::PEVI_H_DONE: begin
        s_nxt.busy = 1'b0;
        s_nxt.st = pevi_pkg::PEVI_H_IDLE;
      end
      default: s_nxt.st = pevi_pkg::PEVI_H_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.st <= pevi_pkg::PEVI_H_IDLE;
      s_r.ctrl <= 3'b010;
      s_r.hready_out <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout = s_r.hready_out;
  assign hresp = 1'b0;
  assign hrdata = s_r.hrdata;
  assign mgmt.req = (s_r.st == pevi_pkg::PEVI_H_REQ);
  assign mgmt.wr = s_r.wr;
  assign mgmt.addr = s_r.addr;
  assign mgmt.wdata = s_r.wdata;
  assign irq_global_en = s_r.ctrl[`PEVI_CTRL_IRQ_EN];
  assign irq_polarity = s_r.ctrl[`PEVI_CTRL_POL];
  assign irq_out_en = s_r.ctrl[`PEVI_CTRL_OUT_EN];
endmodule
